// ==== pkg/vmesr_pkg.sv ====
// Constants for the slave image, receive FIFO view and control/status register group.
// Assumes a 32-bit local register port addressed by register number.
package vmesr_pkg;
   // ----------------------------------------
   // Register numbers
   // ----------------------------------------
   localparam logic [7:0] REG_RX_ADDR  = 8'h18;
   localparam logic [7:0] REG_RX_DATA  = 8'h14;
   localparam logic [7:0] REG_IMAGE    = 8'h10;
   localparam logic [7:0] REG_CSR      = 8'h0c;
   // ----------------------------------------
   // Image register fields
   // ----------------------------------------
   localparam int LONG_BASE_LSB  = 0;
   localparam int LONG_SIZE_LSB  = 5;
   localparam int SHORT_BASE_LSB = 16;
   localparam int SHORT_SIZE_LSB = 21;
   localparam int LONG_PAGE_LSB  = 27;
   localparam int SHORT_PAGE_LSB = 19;
   localparam int LONG_MIN_LSB   = 12;
   // ----------------------------------------
   // Control and status fields
   // ----------------------------------------
   localparam int CSR_TX_CLEAR   = 16;
   localparam int CSR_RX_CLEAR   = 17;
   localparam int CSR_RX_ADVANCE = 18;
   localparam int CSR_BASE_READY = 19;
   localparam int CSR_BP_ERR     = 2;
   localparam int CSR_LOC_ERR    = 3;
   localparam int CSR_MON_OCC    = 4;
   localparam int CSR_DMA_ERR    = 5;
   localparam int CSR_TX_OCC     = 6;
   localparam int CSR_RX_OCC     = 7;
   localparam int CSR_IMG_EN     = 8;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ==== rtl/vmesr_flag.sv ====
// Sticky error flag: hardware sets, software clears by writing zero.
// Assumes a same-clock event pulse and write strobe.
`timescale 1ns/1ns
`default_nettype none
module vmesr_flag (
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic i_ce,
   input  wire logic i_set,
   input  wire logic i_wr,
   input  wire logic i_wdata,
   output logic      o_flag
);
   logic flag_r;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         flag_r <= 1'b0;
      end else if (i_ce) begin
         // Setting wins over a clear in the same cycle so no event is lost.
         flag_r <= i_set | (flag_r & ~(i_wr & ~i_wdata));
      end
   end
   assign o_flag = flag_r;
endmodule
`default_nettype wire

// ==== rtl/vmesr_image_match.sv ====
// Slave image address comparator for the short and long spaces.
// Assumes registered, same-clock address and control inputs.
`timescale 1ns/1ns
`default_nettype none
module vmesr_image_match
   import vmesr_pkg::*;
(
   input  wire logic        i_long,
   input  wire logic [31:0] i_addr,
   input  wire logic [4:0]  i_short_base,
   input  wire logic [1:0]  i_short_size,
   input  wire logic [4:0]  i_long_base,
   input  wire logic [3:0]  i_long_size,
   output logic             o_hit,
   output logic [31:0]      o_mask
);
   logic [4:0] sbmask;
   always_comb begin
      sbmask = 5'h1f << i_short_size;
      o_mask = 32'hffff_ffff << (LONG_MIN_LSB + 32'(i_long_size));
      if (i_long) begin
         // Image spans at most one 128M page, so the whole page must match.
         o_hit = (i_addr[31:LONG_PAGE_LSB] == i_long_base) &&
                 ((i_addr & o_mask & 32'h07ff_ffff) == 32'h0000_0000);
      end else begin
         o_mask = {8'h00, 24'hff_ffff << (SHORT_PAGE_LSB + 32'(i_short_size))};
         o_hit  = ((i_addr[23:SHORT_PAGE_LSB] & sbmask) ==
                   (i_short_base & sbmask));
      end
   end
endmodule
`default_nettype wire

// ==== rtl/vmesr_regs.sv ====
// Register group: receive FIFO output view, slave image base/size, control/status.
// Assumes FIFOs, DMA and bus engines outside; pin-level error inputs are asynchronous.
//
// Operation
// - Receive address reads FIFO output, masked by size.
// - Receive data reads FIFO output word.
// - Short image size codes 512K to 4M.
// - Short base compared with A23-A19, masked.
// - Long image size 4K doubling to 128M.
// - Long base places image in 128M steps.
// - Base ready flag reads zero until programmed.
// - Writing one advances receive FIFO, self clears.
// - Writing one empties receive FIFO, self clears.
// - Writing one empties transmit FIFO, aborts cycle.
// - Receive occupied flag shows FIFO not empty.
// - Transmit occupied flag shows FIFO not empty.
// - DMA local error sticky, raises general interrupt.
// - Monitor occupied flag drives monitor interrupt.
// - Decoupled local error sticky, raises general interrupt.
// - Decoupled backplane error sticky, freezes transmit, interrupts.
// - Image enable control gates all slave images.
`timescale 1ns/1ns
`default_nettype none
module vmesr_regs
   import vmesr_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_ce,
   // ----------------------------------------
   // Local register port
   // ----------------------------------------
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_num,
   input  wire logic [31:0] i_reg_wdata,
   output logic [31:0]      o_reg_rdata,
   // ----------------------------------------
   // Receive FIFO output stage
   // ----------------------------------------
   input  wire logic [31:0] i_rx_addr,
   input  wire logic [31:0] i_rx_data,
   input  wire logic [31:0] i_rx_mask,
   input  wire logic        i_rx_nonempty,
   output logic             o_rx_advance,
   output logic             o_rx_clear,
   // ----------------------------------------
   // Transmit FIFO and monitor status
   // ----------------------------------------
   input  wire logic        i_tx_nonempty,
   output logic             o_tx_clear,
   output logic             o_tx_freeze,
   input  wire logic        i_mon_nonempty,
   // ----------------------------------------
   // Error events
   // ----------------------------------------
   input  wire logic        i_dma_local_err,
   input  wire logic        i_local_bus_error_in,
   input  wire logic        i_backplane_berr,
   input  wire logic        i_decoupled,
   // ----------------------------------------
   // Backplane slave access probe
   // ----------------------------------------
   input  wire logic        i_vme_valid,
   input  wire logic        i_vme_long,
   input  wire logic [31:0] i_vme_addr,
   output logic             o_vme_accept,
   output logic [31:0]      o_vme_mask,
   // ----------------------------------------
   // Interrupt pins
   // ----------------------------------------
   output logic             o_general_irq_out,
   output logic             o_monitor_irq_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0]  short_image_size;
      logic [4:0]  short_image_base;
      logic [3:0]  long_image_size;
      logic [4:0]  long_image_base;
      logic        base_ready_flag;
      logic        image_enable_ctl;
      logic        receive_advance_cmd;
      logic        receive_clear_cmd;
      logic        transmit_clear_cmd;
      logic [1:0]  local_error_flag_sync;
      logic [1:0]  backplane_error_flag_sync;
      logic [31:0] rdata;
      logic        accept;
      logic [31:0] mask;
      logic        gen_irq;
      logic        mon_irq;
      logic        tx_freeze;
   } vmesr_state_type;

   vmesr_state_type st_r;
   vmesr_state_type st_nxt;

   logic        dma_err;
   logic        loc_err;
   logic        bp_err;
   logic        csr_wr;
   logic        hit;
   logic [31:0] hit_mask;

   assign csr_wr = i_reg_wr && (i_reg_num == REG_CSR);

   // ----------------------------------------
   // Sticky error flags
   // ----------------------------------------
   vmesr_flag u_dma_err (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_set   (i_dma_local_err),
      .i_wr    (csr_wr),
      .i_wdata (i_reg_wdata[CSR_DMA_ERR]),
      .o_flag  (dma_err)
   );

   // Local and backplane errors only latch in decoupled mode; atomic mode hands them straight to the CPU.
   vmesr_flag u_loc_err (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_set   (st_r.local_error_flag_sync[1] & i_decoupled),
      .i_wr    (csr_wr),
      .i_wdata (i_reg_wdata[CSR_LOC_ERR]),
      .o_flag  (loc_err)
   );

   vmesr_flag u_bp_err (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_set   (st_r.backplane_error_flag_sync[1] & i_decoupled),
      .i_wr    (csr_wr),
      .i_wdata (i_reg_wdata[CSR_BP_ERR]),
      .o_flag  (bp_err)
   );

   vmesr_image_match u_match (
      .i_long       (i_vme_long),
      .i_addr       (i_vme_addr),
      .i_short_base (st_r.short_image_base),
      .i_short_size (st_r.short_image_size),
      .i_long_base  (st_r.long_image_base),
      .i_long_size  (st_r.long_image_size),
      .o_hit        (hit),
      .o_mask       (hit_mask)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.local_error_flag_sync = {st_r.local_error_flag_sync[0], i_local_bus_error_in};
      st_nxt.backplane_error_flag_sync = {st_r.backplane_error_flag_sync[0], i_backplane_berr};
      st_nxt.receive_advance_cmd = 1'b0;
      st_nxt.receive_clear_cmd   = 1'b0;
      st_nxt.transmit_clear_cmd  = 1'b0;
      if (i_reg_wr && i_reg_num == REG_IMAGE) begin
         st_nxt.short_image_size = i_reg_wdata[SHORT_SIZE_LSB +: 2];
         st_nxt.short_image_base = i_reg_wdata[SHORT_BASE_LSB +: 5];
         st_nxt.long_image_size  = i_reg_wdata[LONG_SIZE_LSB +: 4];
         st_nxt.long_image_base  = i_reg_wdata[LONG_BASE_LSB +: 5];
         st_nxt.base_ready_flag  = 1'b1;
      end
      if (csr_wr) begin
         st_nxt.receive_advance_cmd = i_reg_wdata[CSR_RX_ADVANCE];
         st_nxt.receive_clear_cmd   = i_reg_wdata[CSR_RX_CLEAR];
         st_nxt.transmit_clear_cmd  = i_reg_wdata[CSR_TX_CLEAR];
         st_nxt.image_enable_ctl    = i_reg_wdata[CSR_IMG_EN];
      end
      // Pulse outputs are one cycle wide; reads never see them set.
      st_nxt.rdata = ZERO_WORD;
      if (i_reg_rd) begin
         unique case (i_reg_num)
            REG_RX_ADDR: st_nxt.rdata = i_rx_addr & ~i_rx_mask;
            REG_RX_DATA: st_nxt.rdata = i_rx_data;
            REG_IMAGE: begin
               st_nxt.rdata[SHORT_SIZE_LSB +: 2] = st_r.short_image_size;
               st_nxt.rdata[SHORT_BASE_LSB +: 5] = st_r.short_image_base;
               st_nxt.rdata[LONG_SIZE_LSB +: 4]  = st_r.long_image_size;
               st_nxt.rdata[LONG_BASE_LSB +: 5]  = st_r.long_image_base;
            end
            REG_CSR: begin
               st_nxt.rdata[CSR_BASE_READY] = st_r.base_ready_flag;
               st_nxt.rdata[CSR_RX_OCC]     = i_rx_nonempty;
               st_nxt.rdata[CSR_TX_OCC]     = i_tx_nonempty;
               st_nxt.rdata[CSR_DMA_ERR]    = dma_err;
               st_nxt.rdata[CSR_MON_OCC]    = i_mon_nonempty;
               st_nxt.rdata[CSR_LOC_ERR]    = loc_err;
               st_nxt.rdata[CSR_BP_ERR]     = bp_err;
               st_nxt.rdata[CSR_IMG_EN]     = st_r.image_enable_ctl;
            end
            default: st_nxt.rdata = ZERO_WORD;
         endcase
      end
      st_nxt.accept = i_vme_valid && hit && st_r.image_enable_ctl
                      && st_r.base_ready_flag;
      st_nxt.mask    = hit_mask;
      st_nxt.gen_irq = dma_err | loc_err | bp_err;
      st_nxt.mon_irq = i_mon_nonempty;
      // Freeze lifts only when software clears the flag.
      st_nxt.tx_freeze = bp_err;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_r <= '0;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_reg_rdata       = st_r.rdata;
   assign o_rx_advance      = st_r.receive_advance_cmd;
   assign o_rx_clear        = st_r.receive_clear_cmd;
   assign o_tx_clear        = st_r.transmit_clear_cmd;
   assign o_tx_freeze       = st_r.tx_freeze;
   assign o_vme_accept      = st_r.accept;
   assign o_vme_mask        = st_r.mask;
   assign o_general_irq_out = st_r.gen_irq;
   assign o_monitor_irq_out = st_r.mon_irq;
endmodule
`default_nettype wire

// ==== verif/test_vmesr_regs.sv ====
// Self-checking bench for the register group and its far-side FIFO model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
`default_nettype none
module test_vmesr_regs;
   import vmesr_pkg::*;
   typedef struct {logic lng; logic [31:0] img; logic [31:0] addr; logic acc;} vmesr_row_type;
   logic i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic i_vme_valid = 1'b0, i_vme_long = 1'b0, i_dma_local_err = 1'b0, i_decoupled = 1'b0;
   logic i_mon_nonempty = 1'b0, i_local_bus_error_in = 1'b0, i_backplane_berr = 1'b0;
   logic rx_push = 1'b0, tx_push = 1'b0;
   logic [7:0] i_reg_num = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0, i_vme_addr = 32'h0, i_rx_mask = 32'hfff00000;
   logic [31:0] o_reg_rdata, i_rx_addr, i_rx_data, o_vme_mask;
   logic o_rx_advance, o_rx_clear, o_tx_clear, o_tx_freeze, o_vme_accept;
   logic o_general_irq_out, o_monitor_irq_out, i_rx_nonempty, i_tx_nonempty;
   int miscompares = 0, samples_checked = 0;
   vmesr_row_type rows[12];
   vmesr_regs vmesr_regs_inst (.*);
   vmesr_fifo_model vmesr_fifo_model_inst (.i_clk(i_clk), .i_rx_push(rx_push),
      .i_rx_advance(o_rx_advance), .i_rx_clear(o_rx_clear), .i_tx_push(tx_push),
      .i_tx_clear(o_tx_clear), .o_rx_addr(i_rx_addr), .o_rx_data(i_rx_data),
      .o_rx_nonempty(i_rx_nonempty), .o_tx_nonempty(i_tx_nonempty));
   always #10 i_clk = ~i_clk;
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wreg(logic [7:0] n, logic [31:0] d);
      i_reg_num = n;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick(1);
      i_reg_wr = 1'b0;
   endtask
   task automatic rreg(string nm, logic [7:0] n, logic [31:0] m, logic [31:0] e);
      i_reg_num = n;
      i_reg_rd = 1'b1;
      tick(1);
      i_reg_rd = 1'b0;
      chk(nm, o_reg_rdata & m, e);
      // One idle edge keeps back-to-back reads from re-raising the strobe at once.
      tick(1);
   endtask
   task automatic cbit(string nm, int b, logic [31:0] e);
      rreg(nm, REG_CSR, 32'h1 << b, e << b);
   endtask
   task automatic apulse(bit j);
      // Held for four cycles so the two-stage synchroniser cannot miss it.
      if (j) i_backplane_berr = 1'b1;
      else i_local_bus_error_in = 1'b1;
      tick(4);
      i_backplane_berr = 1'b0;
      i_local_bus_error_in = 1'b0;
      tick(5);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #(20 * 3000);
      miscompares++;
      close_out();
   end
   initial begin
      rows = '{'{0, 32'h00030000, 32'h001ffffc, 1}, '{0, 32'h00030000, 32'h00200000, 0},
         '{0, 32'h00250000, 32'h00200000, 1}, '{0, 32'h00250000, 32'h00300000, 0},
         '{0, 32'h00470000, 32'h003ffffc, 1}, '{0, 32'h00470000, 32'h00400000, 0},
         '{0, 32'h007f0000, 32'h00c00000, 1}, '{0, 32'h007f0000, 32'h00bffffc, 0},
         '{1, 32'h00000003, 32'h18000ffc, 1}, '{1, 32'h00000003, 32'h18001000, 0},
         '{1, 32'h000001e3, 32'h1ffffffc, 1}, '{1, 32'h000001ff, 32'hfffffffc, 1}};
      tick(20);
      i_srst = 1'b0;
      tick(1);
      rreg("csr reset", REG_CSR, 32'hffffffff, ZERO_WORD);
      rreg("unmapped", 8'h40, 32'hffffffff, ZERO_WORD);
      $display("test end: reset");
      wreg(REG_CSR, 32'h100);
      cbit("image enable", CSR_IMG_EN, 1);
      foreach (rows[i]) begin
         wreg(REG_IMAGE, rows[i].img);
         rreg("image", REG_IMAGE, 32'hffffffff, rows[i].img);
         i_vme_valid = 1'b1;
         i_vme_long = rows[i].lng;
         i_vme_addr = rows[i].addr;
         tick(1);
         i_vme_valid = 1'b0;
         chk("accept", {31'h0, o_vme_accept}, {31'h0, rows[i].acc});
         chk("mask", o_vme_mask, rows[i].lng ?
             32'hffffffff << (LONG_MIN_LSB + int'(rows[i].img[8:5])) :
             {8'h00, 24'hffffff << (SHORT_PAGE_LSB + int'(rows[i].img[22:21]))});
      end
      cbit("base ready", CSR_BASE_READY, 1);
      wreg(REG_CSR, 32'h0);
      i_vme_valid = 1'b1;
      tick(1);
      i_vme_valid = 1'b0;
      chk("disabled", {31'h0, o_vme_accept}, 32'h0);
      // A write while the clock enable is low must leave every register alone.
      i_ce = 1'b0;
      wreg(REG_CSR, 32'h100);
      i_ce = 1'b1;
      cbit("frozen", CSR_IMG_EN, 0);
      $display("test end: images");
      for (int k = 0; k < 4; k++) begin
         wreg(REG_CSR, (k < 3) ? 32'h1 << (16 + k) : 32'h0);
         chk("pulse", {29'h0, o_rx_advance, o_rx_clear, o_tx_clear},
             (k < 3) ? 32'h1 << k : 32'h0);
         tick(1);
         chk("pulse end", {29'h0, o_rx_advance, o_rx_clear, o_tx_clear}, 32'h0);
      end
      rreg("cmd bits", REG_CSR, 32'h70000, ZERO_WORD);
      rx_push = 1'b1;
      tx_push = 1'b1;
      tick(2);
      rx_push = 1'b0;
      tx_push = 1'b0;
      tick(1);
      cbit("rx occ", CSR_RX_OCC, 1);
      cbit("tx occ", CSR_TX_OCC, 1);
      rreg("rx addr", REG_RX_ADDR, 32'hffffffff, i_rx_addr & ~i_rx_mask);
      rreg("rx data", REG_RX_DATA, 32'hffffffff, i_rx_data);
      for (int k = 1; k >= 0; k--) begin
         wreg(REG_CSR, 32'h40000);
         tick(2);
         cbit("rx advance", CSR_RX_OCC, k);
      end
      rx_push = 1'b1;
      tick(2);
      rx_push = 1'b0;
      wreg(REG_CSR, 32'h20000);
      tick(2);
      cbit("rx clear", CSR_RX_OCC, 0);
      wreg(REG_CSR, 32'h10000);
      tick(2);
      cbit("tx clear", CSR_TX_OCC, 0);
      $display("test end: fifo");
      i_dma_local_err = 1'b1;
      tick(1);
      i_dma_local_err = 1'b0;
      tick(2);
      chk("dma irq", {31'h0, o_general_irq_out}, 32'h1);
      wreg(REG_CSR, 32'h20);
      tick(1);
      cbit("dma keep", CSR_DMA_ERR, 1);
      wreg(REG_CSR, 32'h0);
      tick(2);
      cbit("dma clear", CSR_DMA_ERR, 0);
      apulse(0);
      cbit("coupled", CSR_LOC_ERR, 0);
      i_decoupled = 1'b1;
      apulse(0);
      cbit("loc err", CSR_LOC_ERR, 1);
      apulse(1);
      cbit("bp err", CSR_BP_ERR, 1);
      chk("freeze", {31'h0, o_tx_freeze}, 32'h1);
      wreg(REG_CSR, 32'h0);
      tick(2);
      chk("unfreeze", {31'h0, o_tx_freeze}, 32'h0);
      chk("irq idle", {31'h0, o_general_irq_out}, 32'h0);
      i_mon_nonempty = 1'b1;
      tick(2);
      cbit("mon occ", CSR_MON_OCC, 1);
      chk("mon irq", {31'h0, o_monitor_irq_out}, 32'h1);
      $display("test end: errors");
      close_out();
   end
endmodule
`default_nettype wire

// ==== verif/vmesr_fifo_model.sv ====
// Far-side model: receive and transmit FIFO occupancy and receive output stage.
// Assumes the block's clock and its one-cycle command pulses.
`timescale 1ns/1ns
`default_nettype none
module vmesr_fifo_model (
   input  wire logic        i_clk,
   input  wire logic        i_rx_push,
   input  wire logic        i_rx_advance,
   input  wire logic        i_rx_clear,
   input  wire logic        i_tx_push,
   input  wire logic        i_tx_clear,
   output logic [31:0]      o_rx_addr,
   output logic [31:0]      o_rx_data,
   output logic             o_rx_nonempty,
   output logic             o_tx_nonempty
);
   logic [3:0] rx_cnt = 4'h0;
   logic [3:0] tx_cnt = 4'h0;
   logic       rx_pop;
   assign rx_pop = i_rx_advance && (rx_cnt != 4'h0);
   always @(posedge i_clk) begin
      rx_cnt <= i_rx_clear ? 4'h0 : rx_cnt + {3'h0, i_rx_push} - {3'h0, rx_pop};
      tx_cnt <= i_tx_clear ? 4'h0 : tx_cnt + {3'h0, i_tx_push};
   end
   // An empty stage shows the inverted pattern, so a stale word never looks fresh.
   assign o_rx_nonempty = rx_cnt != 4'h0;
   assign o_tx_nonempty = tx_cnt != 4'h0;
   assign o_rx_addr = o_rx_nonempty ? {28'h2c5a3b1, rx_cnt} : ~{28'h2c5a3b1, rx_cnt};
   assign o_rx_data = o_rx_nonempty ? {28'h9e07d4c, rx_cnt} : ~{28'h9e07d4c, rx_cnt};
endmodule
`default_nettype wire

// ==== verif/vmesr_regs_chk.sv ====
// Checker for the register group, bound to its top module.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module vmesr_regs_chk
   import vmesr_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic        i_ce,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [7:0]  i_reg_num,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [31:0] o_reg_rdata,
   input wire logic [31:0] i_rx_data,
   input wire logic        o_rx_advance,
   input wire logic        o_rx_clear,
   input wire logic        o_tx_clear,
   input wire logic        o_tx_freeze,
   input wire logic        i_mon_nonempty,
   input wire logic        i_dma_local_err,
   input wire logic        i_local_bus_error_in,
   input wire logic        i_backplane_berr,
   input wire logic        i_decoupled,
   input wire logic        i_vme_valid,
   input wire logic        o_vme_accept,
   input wire logic        o_general_irq_out,
   input wire logic        o_monitor_irq_out
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire logic csr_wr = i_ce && i_reg_wr && i_reg_num == REG_CSR;
   wire logic adv_req = csr_wr && i_reg_wdata[CSR_RX_ADVANCE];
   wire logic rxc_req = csr_wr && i_reg_wdata[CSR_RX_CLEAR];
   wire logic txc_req = csr_wr && i_reg_wdata[CSR_TX_CLEAR];
   adv_pulse_a: assert property (i_ce |=> o_rx_advance == $past(adv_req))
      else $error("advance pulse wrong");
   rx_clear_a: assert property (i_ce |=> o_rx_clear == $past(rxc_req))
      else $error("receive clear pulse wrong");
   tx_clear_a: assert property (i_ce |=> o_tx_clear == $past(txc_req))
      else $error("transmit clear pulse wrong");
   mon_irq_a: assert property (i_ce |=> o_monitor_irq_out == $past(i_mon_nonempty))
      else $error("monitor interrupt wrong");
   dma_irq_a: assert property (
      i_ce && i_dma_local_err |-> ##[1:3] o_general_irq_out)
      else $error("dma error gave no interrupt");
   loc_irq_a: assert property (
      (i_decoupled && i_local_bus_error_in) [*3] |-> ##[1:4] o_general_irq_out)
      else $error("local error gave no interrupt");
   bp_freeze_a: assert property (
      (i_decoupled && i_backplane_berr) [*3] |-> ##[1:4] o_tx_freeze)
      else $error("backplane error gave no freeze");
   rx_data_a: assert property (
      i_ce && i_reg_rd && i_reg_num == REG_RX_DATA |=> o_reg_rdata == $past(i_rx_data))
      else $error("receive data read wrong");
   accept_cause_a: assert property (o_vme_accept |-> $past(i_vme_valid))
      else $error("accept without access");
endmodule
bind vmesr_regs vmesr_regs_chk vmesr_regs_chk_inst (.*);
`default_nettype wire
